// [pkg/fpece_pkg.sv]
// Shared constants of the flash program/erase command engine
package fpece_pkg;

   // ==========================================================
   // Clock
   localparam int CLK_PERIOD_NS = 100;

   // ==========================================================
   // Command codes held in parameter byte zero
   localparam logic [7:0] CMD_PROGRAM_CHECK = 8'h02;
   localparam logic [7:0] CMD_READ_RESOURCE = 8'h03;
   localparam logic [7:0] CMD_PROGRAM_LONGWORD = 8'h06;
   localparam logic [7:0] CMD_SECTOR_ERASE = 8'h09;

   // ==========================================================
   // Margin choices and resource select codes
   localparam logic [7:0] MARGIN_CHOICE_USER = 8'h01;
   localparam logic [7:0] MARGIN_CHOICE_FACTORY = 8'h02;
   localparam logic [7:0] RSRC_INFO_ROW = 8'h00;
   localparam logic [7:0] RSRC_VERSION = 8'h01;
   localparam logic [23:0] INFO_ROW_LAST = 24'h0000FF;
   localparam logic [23:0] VERSION_LAST = 24'h000007;
   localparam logic [1:0] ALIGNED_LOW_BITS = 2'h0;

   // ==========================================================
   // Margin levels driven to the array
   localparam logic [1:0] LEVEL_NORMAL = 2'h0;
   localparam logic [1:0] LEVEL_USER = 2'h1;
   localparam logic [1:0] LEVEL_FACTORY = 2'h2;

   // ==========================================================
   // Field positions in the parameter bytes
   localparam int PB_CMD = 0;
   localparam int PB_ADDR_HI = 1;
   localparam int PB_ADDR_MID = 2;
   localparam int PB_ADDR_LO = 3;
   localparam int PB_MARGIN = 4;
   localparam int PB_DATA0 = 4;
   localparam int PB_EXPECT0 = 8;
   localparam int PB_RSRC = 8;
   localparam int PARAM_BYTES = 12;

   // ==========================================================
   // Embedded algorithm timing, least times rounded up
   localparam int PROGRAM_TIME_NS = 5000;
   localparam int PROGRAM_CYCLES = (PROGRAM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_STEP_TIME_NS = 2000;
   localparam int ERASE_STEP_CYCLES = (ERASE_STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] PROGRAM_RELOAD = 8'(PROGRAM_CYCLES - 1);
   localparam logic [7:0] ERASE_STEP_RELOAD = 8'(ERASE_STEP_CYCLES - 1);

   // ==========================================================
   // Array geometry defaults, erased word value and values after reset
   localparam int DEFAULT_ARRAY_WORDS = 1024;
   localparam int DEFAULT_SECTOR_WORDS = 256;
   localparam int DEFAULT_REGIONS = 4;
   localparam logic [31:0] ERASED_WORD = 32'hFFFFFFFF;
   localparam logic [31:0] RETURN_DATA_RESET = 32'h00000000;
   localparam logic COMPLETE_RESET = 1'b1;

endpackage

// [src/fpece_flash_array.sv]
// Program flash longword array with registered read data
`timescale 1ns/1ps
module fpece_flash_array #(
   parameter int WORDS = fpece_pkg::DEFAULT_ARRAY_WORDS
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Access strobes
   input wire logic read_i,
   input wire logic program_i,
   input wire logic erase_i,
   // Address and data
   input wire logic [$clog2(WORDS)-1:0] addr_i,
   input wire logic [31:0] data_i,
   output logic [31:0] read_data_o
);

   // ==========================================================
   // Geometry check
   if (WORDS < 4 || (WORDS & (WORDS - 1)) != 0) begin : g_bad_words
      $error("fpece_flash_array: bad WORDS");
   end

   // ==========================================================
   // Storage, not reset since it is nonvolatile
   logic [31:0] mem [WORDS];

   // Program only pulls bits to zero, erase returns a word to ones
   always_ff @(posedge clock_i) begin
      if (erase_i) begin
         mem[addr_i] <= fpece_pkg::ERASED_WORD;
      end else if (program_i) begin
         mem[addr_i] <= mem[addr_i] & data_i;
      end
   end

   // Read port, one cycle latency
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         read_data_o <= fpece_pkg::RETURN_DATA_RESET;
      end else if (read_i) begin
         read_data_o <= mem[addr_i];
      end
   end

endmodule

// [src/fpece_resource_rom.sv]
// Special resources: information row and version field
`timescale 1ns/1ps
module fpece_resource_rom #(
   // Arbitrary value, stands for a factory identity
   parameter logic [63:0] VERSION_ID = 64'h0123456789ABCDEF
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Read request
   input wire logic read_i,
   input wire logic select_version_i,
   input wire logic [5:0] word_i,
   output logic [31:0] read_data_o
);

   // ==========================================================
   // Lookup, the information row is delivered blank
   logic [31:0] version_word;
   logic [31:0] lookup;
   assign version_word = word_i[0] ? VERSION_ID[31:0] : VERSION_ID[63:32];
   assign lookup = select_version_i ? version_word : fpece_pkg::ERASED_WORD;

   // Registered read data
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         read_data_o <= fpece_pkg::RETURN_DATA_RESET;
      end else if (read_i) begin
         read_data_o <= lookup;
      end
   end

endmodule

// [src/fpece_engine.sv]
// Flash program/erase command engine: decode, checks, algorithms, flags
`timescale 1ns/1ps

// How it works
// RULE1 - Program check takes address, margin, expected bytes
// RULE2 - Ones-margin read compares, mismatch sets margin fail
// RULE3 - Zeros-margin pass follows; completion after both
// RULE4 - Margin choice only user or factory, else error
// RULE5 - Bad or unaligned address raises access error
// RULE6 - Commands refused in disallowed mode or security
// RULE7 - Byte three lands at start address, reversed
// RULE8 - Read resource returns four bytes, high first
// RULE9 - Code zero info row, code one version
// RULE10 - Unknown code or out-of-range address errors
// RULE11 - Program longword writes bytes four to seven
// RULE12 - Verify flags zeros that failed to program
// RULE13 - Protected program target sets violation, no write
// RULE14 - Software programs only erased locations once
// RULE15 - Sector erase, then verify, then completion
// RULE16 - Protected sector aborts erase with violation
// RULE17 - Only sector erase can be suspended
// RULE18 - Sampled suspend request halts erase, sets completion
// RULE19 - Request still set at launch resumes, clears it
// RULE20 - No launch while error flags are set
// RULE21 - Failed checks complete without array or return
module fpece_engine #(
   parameter int ARRAY_WORDS = fpece_pkg::DEFAULT_ARRAY_WORDS,
   parameter int SECTOR_WORDS = fpece_pkg::DEFAULT_SECTOR_WORDS,
   parameter int REGIONS = fpece_pkg::DEFAULT_REGIONS
) (
   // Clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // Launch and flag clearing from software
   input wire logic launch_i,
   input wire logic clear_access_error_i,
   input wire logic clear_protection_violation_i,
   input wire logic [8*fpece_pkg::PARAM_BYTES-1:0] command_parameter_bytes_i,
   // Erase suspend request bit
   input wire logic suspend_set_i,
   input wire logic suspend_clear_i,
   // Mode, security and protection
   input wire logic special_mode_i,
   input wire logic secure_i,
   input wire logic [REGIONS-1:0] region_protection_regs_i,
   // Status flags
   output logic command_complete_flag_o,
   output logic access_error_flag_o,
   output logic protection_violation_flag_o,
   output logic margin_check_fail_flag_o,
   output logic erase_suspend_request_o,
   // Returned parameter bytes four to seven
   output logic return_write_o,
   output logic [31:0] return_data_o,
   // Read margin applied to the array
   output logic [1:0] margin_level_o,
   output logic margin_zeros_o
);

   localparam int AW = $clog2(ARRAY_WORDS);
   localparam int SW = $clog2(SECTOR_WORDS);
   localparam int RW = $clog2(REGIONS);
   localparam logic [24:0] ARRAY_BYTES = 25'(ARRAY_WORDS * 4);

   // ==========================================================
   // Geometry checks
   if (AW + 2 > 24 || SECTOR_WORDS < 2 || SECTOR_WORDS > ARRAY_WORDS
         || (SECTOR_WORDS & (SECTOR_WORDS - 1)) != 0) begin : g_bad_geometry
      $error("fpece_engine: bad geometry");
   end
   if (REGIONS < 2 || REGIONS > ARRAY_WORDS || (REGIONS & (REGIONS - 1)) != 0) begin : g_bad_regions
      $error("fpece_engine: bad REGIONS");
   end

   // ==========================================================
   // Byte picker, used for every field
   function automatic logic [7:0] pbyte(input logic [95:0] p, input int n);
      pbyte = p[8*n +: 8];
   endfunction

   typedef enum logic [3:0] {
      S_IDLE,
      S_DECODE,
      S_PROGRAM,
      S_ERASE,
      S_READ,
      S_COMPARE,
      S_RSRC_READ,
      S_RSRC_RETURN,
      S_FINISH
   } fpece_state_t;

   fpece_state_t state;
   logic [95:0] param_q;
   logic [SW-1:0] erase_idx;
   logic [7:0] timer;
   logic suspended;

   // ==========================================================
   // Fields of the latched parameter bytes
   logic [7:0] cmd;
   logic [23:0] addr;
   logic [7:0] margin_choice;
   logic [7:0] rsrc_sel;
   logic [31:0] program_word;
   logic [31:0] expected_word;
   logic [AW-1:0] word_idx;
   logic [AW-SW-1:0] sector_idx;
   logic [RW-1:0] region_idx;
   assign cmd = pbyte(param_q, fpece_pkg::PB_CMD);
   assign addr = {pbyte(param_q, fpece_pkg::PB_ADDR_HI), pbyte(param_q, fpece_pkg::PB_ADDR_MID),
                  pbyte(param_q, fpece_pkg::PB_ADDR_LO)}; // RULE1
   assign margin_choice = pbyte(param_q, fpece_pkg::PB_MARGIN); // RULE1
   assign rsrc_sel = pbyte(param_q, fpece_pkg::PB_RSRC);
   // Byte three, top lane, goes to the start address
   assign program_word = {pbyte(param_q, fpece_pkg::PB_DATA0 + 3),
                          pbyte(param_q, fpece_pkg::PB_DATA0 + 2),
                          pbyte(param_q, fpece_pkg::PB_DATA0 + 1),
                          pbyte(param_q, fpece_pkg::PB_DATA0)}; // RULE7 RULE11
   assign expected_word = {pbyte(param_q, fpece_pkg::PB_EXPECT0 + 3),
                           pbyte(param_q, fpece_pkg::PB_EXPECT0 + 2),
                           pbyte(param_q, fpece_pkg::PB_EXPECT0 + 1),
                           pbyte(param_q, fpece_pkg::PB_EXPECT0)}; // RULE1 RULE7
   assign word_idx = addr[AW+1:2];
   assign sector_idx = word_idx[AW-1:SW];
   assign region_idx = word_idx[AW-1:AW-RW];

   // Command kind
   logic is_check;
   logic is_rsrc;
   logic is_program;
   logic is_erase;
   assign is_check = cmd == fpece_pkg::CMD_PROGRAM_CHECK;
   assign is_rsrc = cmd == fpece_pkg::CMD_READ_RESOURCE;
   assign is_program = cmd == fpece_pkg::CMD_PROGRAM_LONGWORD;
   assign is_erase = cmd == fpece_pkg::CMD_SECTOR_ERASE;

   // ==========================================================
   // Checks, all before the array is touched
   logic mode_ok;
   logic aligned;
   logic in_array;
   logic margin_ok;
   logic rsrc_ok;
   logic access_fault;
   logic protect_fault;
   // Secure special mode locks out all four commands
   assign mode_ok = !(special_mode_i && secure_i); // RULE6
   assign aligned = addr[1:0] == fpece_pkg::ALIGNED_LOW_BITS; // RULE5
   assign in_array = {1'b0, addr} < ARRAY_BYTES; // RULE5
   assign margin_ok = margin_choice == fpece_pkg::MARGIN_CHOICE_USER
                   || margin_choice == fpece_pkg::MARGIN_CHOICE_FACTORY; // RULE4
   assign rsrc_ok = (rsrc_sel == fpece_pkg::RSRC_INFO_ROW && addr <= fpece_pkg::INFO_ROW_LAST)
                 || (rsrc_sel == fpece_pkg::RSRC_VERSION && addr <= fpece_pkg::VERSION_LAST); // RULE9 RULE10
   assign access_fault = !(is_check || is_rsrc || is_program || is_erase) || !mode_ok || !aligned
                      || (!is_rsrc && !in_array)
                      || (is_check && !margin_ok)
                      || (is_rsrc && !rsrc_ok); // RULE5 RULE6 RULE10
   // Protection counts only for a sound address
   assign protect_fault = (is_program || is_erase) && region_protection_regs_i[region_idx]; // RULE13 RULE16

   // ==========================================================
   // Sequencing conditions
   logic launch_ok;
   logic resume_now;
   logic timer_done;
   logic erase_last;
   logic suspend_now;
   logic erase_ends;
   // No launch while an error flag stands
   assign launch_ok = state == S_IDLE && launch_i && command_complete_flag_o
                   && !access_error_flag_o && !protection_violation_flag_o; // RULE20
   assign resume_now = launch_ok && suspended && erase_suspend_request_o; // RULE19
   assign timer_done = timer == 8'h00;
   assign erase_last = erase_idx == {SW{1'b1}};
   // Suspend sampled only between erased words
   assign suspend_now = state == S_ERASE && timer_done && !erase_last
                     && erase_suspend_request_o; // RULE17 RULE18
   assign erase_ends = state == S_FINISH && is_erase;

   // ==========================================================
   // Array and resource strobes
   logic arr_read;
   logic arr_program;
   logic arr_erase;
   logic [AW-1:0] arr_addr;
   logic [31:0] arr_data;
   logic [31:0] rom_data;
   logic compare_fail;
   assign arr_read = state == S_READ;
   assign arr_program = state == S_PROGRAM && timer_done; // RULE11
   assign arr_erase = state == S_ERASE && timer_done; // RULE15
   assign arr_addr = is_erase ? {sector_idx, erase_idx} : word_idx;
   // Verify: whole word for check, stuck ones for program
   assign compare_fail = is_check ? arr_data != expected_word // RULE2 RULE3
                       : is_program ? |(arr_data & ~program_word) // RULE12
                       : arr_data != fpece_pkg::ERASED_WORD; // RULE15

   fpece_flash_array #(
      .WORDS(ARRAY_WORDS)
   ) u_array (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .read_i(arr_read),
      .program_i(arr_program),
      .erase_i(arr_erase),
      .addr_i(arr_addr),
      .data_i(program_word),
      .read_data_o(arr_data)
   );

   fpece_resource_rom u_rom (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .read_i(state == S_RSRC_READ),
      .select_version_i(rsrc_sel == fpece_pkg::RSRC_VERSION),
      .word_i(addr[7:2]),
      .read_data_o(rom_data)
   ); // RULE8 RULE9

   // ==========================================================
   // Command state machine
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         state <= S_IDLE;
         param_q <= '0;
         erase_idx <= '0;
         timer <= 8'h00;
         suspended <= 1'b0;
      end else begin
         unique case (state)
            S_IDLE: begin
               if (resume_now) begin
                  timer <= fpece_pkg::ERASE_STEP_RELOAD;
                  state <= S_ERASE; // RULE19
               end else if (launch_ok) begin
                  // A cleared request with a suspended erase aborts it
                  param_q <= command_parameter_bytes_i;
                  suspended <= 1'b0;
                  state <= S_DECODE;
               end
            end
            S_DECODE: begin
               erase_idx <= '0;
               if (access_fault || protect_fault) begin
                  state <= S_FINISH; // RULE21
               end else if (is_check || is_program) begin
                  timer <= fpece_pkg::PROGRAM_RELOAD;
                  state <= is_check ? S_READ : S_PROGRAM;
               end else if (is_rsrc) begin
                  state <= S_RSRC_READ;
               end else begin
                  timer <= fpece_pkg::ERASE_STEP_RELOAD;
                  state <= S_ERASE;
               end
            end
            S_PROGRAM: begin
               if (timer_done) begin
                  state <= S_READ;
               end else begin
                  timer <= timer - 8'h01;
               end
            end
            S_ERASE: begin
               if (timer_done) begin
                  erase_idx <= erase_idx + 1'b1;
                  timer <= fpece_pkg::ERASE_STEP_RELOAD;
                  if (erase_last) begin
                     state <= S_READ;
                  end else if (suspend_now) begin
                     suspended <= 1'b1;
                     state <= S_IDLE; // RULE18
                  end
               end else begin
                  timer <= timer - 8'h01;
               end
            end
            S_READ: begin
               state <= S_COMPARE;
            end
            S_COMPARE: begin
               if (is_check && !margin_zeros_o) begin
                  state <= S_READ; // RULE3
               end else if (is_erase && !erase_last) begin
                  erase_idx <= erase_idx + 1'b1;
                  state <= S_READ;
               end else begin
                  state <= S_FINISH;
               end
            end
            S_RSRC_READ: begin
               state <= S_RSRC_RETURN;
            end
            S_RSRC_RETURN: begin
               state <= S_FINISH;
            end
            S_FINISH: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // Completion: launch clears, end or suspend sets
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         command_complete_flag_o <= fpece_pkg::COMPLETE_RESET;
      end else if (state == S_FINISH || suspend_now) begin
         command_complete_flag_o <= 1'b1; // RULE3 RULE8 RULE15 RULE18
      end else if (launch_ok) begin
         command_complete_flag_o <= 1'b0;
      end
   end

   // Error flags; a set in the clearing cycle wins
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         access_error_flag_o <= 1'b0;
         protection_violation_flag_o <= 1'b0;
      end else begin
         if (state == S_DECODE && access_fault) begin
            access_error_flag_o <= 1'b1; // RULE4 RULE5 RULE6 RULE10
         end else if (clear_access_error_i) begin
            access_error_flag_o <= 1'b0;
         end
         if (state == S_DECODE && !access_fault && protect_fault) begin
            protection_violation_flag_o <= 1'b1; // RULE13 RULE16
         end else if (clear_protection_violation_i) begin
            protection_violation_flag_o <= 1'b0;
         end
      end
   end

   // Margin failure sticks over both passes
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         margin_check_fail_flag_o <= 1'b0;
      end else if (state == S_COMPARE && compare_fail) begin
         margin_check_fail_flag_o <= 1'b1; // RULE2 RULE3 RULE12 RULE15
      end else if (launch_ok) begin
         margin_check_fail_flag_o <= 1'b0;
      end
   end

   // ==========================================================
   // Suspend request: cleared on resume or at erase end
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         erase_suspend_request_o <= 1'b0;
      end else if (resume_now || erase_ends) begin
         erase_suspend_request_o <= 1'b0; // RULE19
      end else if (suspend_set_i && !command_complete_flag_o && is_erase) begin
         erase_suspend_request_o <= 1'b1; // RULE17
      end else if (suspend_clear_i && command_complete_flag_o) begin
         erase_suspend_request_o <= 1'b0;
      end
   end

   // ==========================================================
   // Returned bytes, only from a good resource read
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         return_write_o <= 1'b0;
         return_data_o <= fpece_pkg::RETURN_DATA_RESET;
      end else begin
         return_write_o <= state == S_RSRC_RETURN; // RULE8 RULE21
         if (state == S_RSRC_RETURN) begin
            return_data_o <= rom_data; // RULE8
         end
      end
   end

   // ==========================================================
   // Margin: ones pass, then zeros, else normal
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         margin_level_o <= fpece_pkg::LEVEL_NORMAL;
         margin_zeros_o <= 1'b0;
      end else if (state == S_DECODE && is_check && !access_fault) begin
         margin_level_o <= margin_choice == fpece_pkg::MARGIN_CHOICE_USER
                        ? fpece_pkg::LEVEL_USER : fpece_pkg::LEVEL_FACTORY; // RULE4
         margin_zeros_o <= 1'b0; // RULE2
      end else if (state == S_COMPARE && is_check && !margin_zeros_o) begin
         margin_zeros_o <= 1'b1; // RULE3
      end else if (state == S_FINISH) begin
         margin_level_o <= fpece_pkg::LEVEL_NORMAL;
         margin_zeros_o <= 1'b0;
      end
   end

endmodule

// [tb/fpece_engine_checker.sv]
// Port checker for the flash command engine
`timescale 1ns/1ps
module fpece_engine_checker (
   // Engine inputs
   input wire logic clock_i, rst_i, launch_i, suspend_set_i, suspend_clear_i,
   input wire logic special_mode_i, secure_i,
   input wire logic [8*fpece_pkg::PARAM_BYTES-1:0] command_parameter_bytes_i,
   // Engine outputs
   input wire logic command_complete_flag_o, access_error_flag_o, return_write_o,
   input wire logic protection_violation_flag_o, margin_check_fail_flag_o,
   input wire logic erase_suspend_request_o, margin_zeros_o,
   input wire logic [31:0] return_data_o,
   input wire logic [1:0] margin_level_o
);
   // ==========================================
   // Accepted launch and its margin choice
   wire logic take = launch_i && command_complete_flag_o && !access_error_flag_o
      && !protection_violation_flag_o;
   logic [7:0] choice;
   always_ff @(posedge clock_i) if (take) choice <= command_parameter_bytes_i[39:32];
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // ==========================================
   // Launch, refusal and error timing
   property p_start; take |=> !command_complete_flag_o && !margin_check_fail_flag_o; endproperty
   a_start: assert property (p_start) else $error("launch not taken");
   property p_refuse; launch_i && command_complete_flag_o
      && (access_error_flag_o || protection_violation_flag_o) |=> command_complete_flag_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("launch taken with error set");
   property p_mode; take && special_mode_i && secure_i
      |=> ##1 access_error_flag_o ##2 command_complete_flag_o; endproperty
   a_mode: assert property (p_mode) else $error("refused mode not flagged");
   property p_ret; return_write_o |-> !command_complete_flag_o ##1 command_complete_flag_o;
   endproperty
   a_ret: assert property (p_ret) else $error("no done after return");
   property p_keep; $changed(return_data_o) |-> return_write_o; endproperty
   a_keep: assert property (p_keep) else $error("return bytes changed");
   // ==========================================
   // Margin levels and suspension
   property p_lvl; margin_level_o != 2'h0 |-> margin_level_o == choice[1:0]; endproperty
   a_lvl: assert property (p_lvl) else $error("level not choice");
   property p_zero; $rose(margin_zeros_o) |-> $past(margin_level_o) != 2'h0; endproperty
   a_zero: assert property (p_zero) else $error("zeros before ones");
   property p_susp; erase_suspend_request_o && command_complete_flag_o && !launch_i
      && !suspend_clear_i |=> erase_suspend_request_o; endproperty
   a_susp: assert property (p_susp) else $error("suspend request lost");
   property p_resume; take && erase_suspend_request_o |=> !erase_suspend_request_o;
   endproperty
   a_resume: assert property (p_resume) else $error("resume not acknowledged");
   property p_only; $rose(erase_suspend_request_o) |-> $past(suspend_set_i); endproperty
   a_only: assert property (p_only) else $error("request rose by itself");
endmodule
bind fpece_engine fpece_engine_checker chk_u (.clock_i, .rst_i, .launch_i, .suspend_set_i,
   .suspend_clear_i, .special_mode_i, .secure_i, .command_parameter_bytes_i,
   .command_complete_flag_o, .access_error_flag_o,
   .return_write_o, .protection_violation_flag_o, .margin_check_fail_flag_o,
   .erase_suspend_request_o, .margin_zeros_o, .return_data_o, .margin_level_o);

// [tb/fpece_engine_test.sv]
// Self-checking bench for the flash command engine
`timescale 1ns/1ps
module fpece_engine_test;
   logic clock_i = 0, rst_i = 1, launch_i = 0, clear_access_error_i = 0, suspend_set_i = 0;
   logic clear_protection_violation_i = 0, suspend_clear_i = 0, special_mode_i = 0;
   logic secure_i = 0, pc = 1, command_complete_flag_o, access_error_flag_o, return_write_o;
   logic protection_violation_flag_o, margin_check_fail_flag_o, erase_suspend_request_o;
   logic [95:0] command_parameter_bytes_i = '0;
   logic [3:0] region_protection_regs_i = 4'h2; // Region 1 locked all run
   logic [31:0] return_data_o, w;
   logic [2:0] eq[$];
   logic [31:0] rq[$];
   int bad_count = 0, total_checks = 0;
   fpece_engine dut_u (.clock_i, .rst_i, .launch_i, .clear_access_error_i,
      .clear_protection_violation_i, .command_parameter_bytes_i, .suspend_set_i,
      .suspend_clear_i, .special_mode_i, .secure_i, .region_protection_regs_i,
      .command_complete_flag_o, .access_error_flag_o, .protection_violation_flag_o,
      .margin_check_fail_flag_o, .erase_suspend_request_o, .return_write_o, .return_data_o,
      .margin_level_o(), .margin_zeros_o());
   // ==========================================
   // Clock at 10 MHz
   always #50 clock_i = ~clock_i;
   task automatic chk(input logic [39:0] s, e, input string n);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Pack bytes, address high in byte one
   function automatic logic [95:0] pk(input logic [7:0] c, input logic [23:0] a,
      input logic [31:0] d, x);
      return {x, d, a[7:0], a[15:8], a[23:16], c};
   endfunction
   // Clear flags, launch, note flags, wait
   task automatic go(input logic [95:0] p, input logic [2:0] e);
      int n = 0;
      @(posedge clock_i);
      #10 clear_access_error_i = 1;
      clear_protection_violation_i = 1;
      @(posedge clock_i);
      #10 clear_access_error_i = 0;
      clear_protection_violation_i = 0;
      command_parameter_bytes_i = p;
      launch_i = 1;
      eq.push_back(e);
      @(posedge clock_i);
      #10 launch_i = 0;
      while (!command_complete_flag_o && n < 9000) begin
         @(posedge clock_i);
         #10 n++;
      end
      if (n == 9000) begin
         bad_count++;
         test_done;
      end
   endtask
   // Monitor at falling edge, outputs settled
   always @(negedge clock_i) begin
      if (command_complete_flag_o && !pc && eq.size() > 0)
         chk({access_error_flag_o, protection_violation_flag_o, margin_check_fail_flag_o},
            eq.pop_front(), "flags");
      if (return_write_o && rq.size() > 0)
         chk(return_data_o, rq.pop_front(), "data");
      pc = command_complete_flag_o;
   end
   initial begin
      w = $urandom(84);
      repeat (20) @(posedge clock_i);
      #10 rst_i = 0;
      go(pk(8'h09, 24'h0, 0, 0), 3'h0);
      go(pk(8'h06, 24'h8, w, 0), 3'h0);
      go(pk(8'h02, 24'h8, 32'h1, w), 3'h0);
      go(pk(8'h02, 24'h8, 32'h2, w), 3'h0);
      go(pk(8'h02, 24'h8, 32'h1, ~w), 3'h1);
      go(pk(8'h02, 24'h8, 32'h3, w), 3'h4);
      go(pk(8'h02, 24'hA, 32'h1, w), 3'h4);
      go(pk(8'h06, 24'h1000, w, 0), 3'h4);
      go(pk(8'h06, 24'h400, w, 0), 3'h2);
      go(pk(8'h09, 24'h400, 0, 0), 3'h2);
      // Info row tail, then both version words
      for (int i = 0; i < 3; i++) begin
         rq.push_back(i == 0 ? 32'hFFFFFFFF : i == 1 ? 32'h01234567 : 32'h89ABCDEF);
         go(pk(8'h03, i == 0 ? 24'hFC : 24'(4 * (i - 1)), 0, 32'(i > 0)), 3'h0);
      end
      go(pk(8'h03, 24'h0, 0, 32'h2), 3'h4);
      go(pk(8'h03, 24'h100, 0, 0), 3'h4);
      go(pk(8'h03, 24'h8, 0, 32'h1), 3'h4);
      go(pk(8'h07, 24'h0, 0, 0), 3'h4);
      special_mode_i = 1;
      secure_i = 1;
      go(pk(8'h09, 24'h0, 0, 0), 3'h4);
      // Launch with error set is ignored
      @(posedge clock_i);
      #10 launch_i = 1;
      @(posedge clock_i);
      #10 launch_i = 0;
      chk({command_complete_flag_o, access_error_flag_o, return_data_o},
         {2'h3, 32'h89ABCDEF}, "refused");
      special_mode_i = 0;
      secure_i = 0;
      fork
         go(pk(8'h09, 24'h0, 0, 0), 3'h0);
         begin
            repeat (200) @(posedge clock_i);
            #10 suspend_set_i = 1;
            @(posedge clock_i);
            #10 suspend_set_i = 0;
         end
      join
      chk(erase_suspend_request_o, 1, "suspend");
      go(pk(8'h09, 24'h0, 0, 0), 3'h0);
      chk(erase_suspend_request_o, 0, "resume");
      test_done;
   end
endmodule
